// [design/sac_pkg.sv]
// Shared constants, types and decode functions for the converter control block.
// Assumes a single system clock domain and an AXI4-Lite register bus.
package sac_pkg;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [AW-1:0] OFS_REF = 8'h08;
  localparam logic [AW-1:0] OFS_RES_HI = 8'h0c;
  localparam logic [AW-1:0] OFS_RES_LO = 8'h10;
  localparam logic [AW-1:0] OFS_INT = 8'h14;
  // Field positions
  localparam int C0_START = 7;
  localparam int C0_BUSY = 6;
  localparam int C0_PWR = 5;
  localparam int C0_FMT = 4;
  localparam int C0_CHAN = 0;
  localparam int C1_SRC = 4;
  localparam int C1_DIV = 0;
  localparam int INT_GIE = 0;
  localparam int INT_CIE = 1;
  localparam int INT_FLAG = 2;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [7:0] INT_RST = 8'h00;
  // Conversion timing in conversion-clock periods
  localparam logic [4:0] SAMPLE_TICKS = 5'h04;
  localparam logic [4:0] CONVERT_TICKS = 5'h0c;
  localparam logic [4:0] TOTAL_TICKS = SAMPLE_TICKS + CONVERT_TICKS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SRC_EXT, SRC_SUPPLY, SRC_AMP, SRC_GND} sac_src_t;

  // Analog routing toward the converter core
  typedef struct packed {
    logic ext_en;
    logic [3:0] ext_sel;
    sac_src_t src;
    logic [1:0] div_shift;
  } sac_route_t;

  // Gray-coded along idle, sample, convert
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_CONVERT = 2'b11} sac_state_t;

  // True for a mapped register offset
  function automatic logic reg_hit(input logic [AW-1:0] a);
    reg_hit = (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_REF) ||
              (a == OFS_RES_HI) || (a == OFS_RES_LO) || (a == OFS_INT);
  endfunction : reg_hit

  // Input source code and channel to analog routing
  function automatic sac_route_t decode_route(input logic [3:0] s, input logic [3:0] ch);
    sac_route_t r;
    r.ext_en = 1'b0;
    r.ext_sel = 4'h0;
    r.src = SRC_GND;
    r.div_shift = 2'h0;
    if (s[3:2] == 2'b11 || s[1:0] == 2'b00 && !s[3])
    begin
      r.ext_en = 1'b1;
      r.ext_sel = ch;
      r.src = SRC_EXT;
    end
    else if (s[3:2] == 2'b10)
      r.src = SRC_GND;
    else
    begin
      r.src = s[2] ? SRC_AMP : SRC_SUPPLY;
      r.div_shift = s[1:0] - 2'h1;
    end
    decode_route = r;
  endfunction : decode_route
endpackage : sac_pkg

// [design/sac_clk_div.sv]
// Conversion clock divider: one-cycle tick every 2**sel system clocks.
// Assumes sync_clr realigns the phase at the start of each conversion.
`timescale 1ns/1ns
module sac_clk_div #(
  parameter int DIV_W = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sync_clr,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] lim;

  // Terminal count for the selected ratio 1..128
  assign lim = DIV_W'((8'h01 << sel) - 8'h01);
  assign tick = (cnt_reg == lim) && !sync_clr;

  // Free count, cleared on start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (sync_clr || cnt_reg >= lim)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule : sac_clk_div

// [design/sac_axil_slave.sv]
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file answers rd_data combinationally from rd_addr.
`timescale 1ns/1ns
module sac_axil_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [sac_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sac_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [sac_pkg::AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [sac_pkg::AW-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  import sac_pkg::*;
  logic aw_hold_reg;
  logic w_hold_reg;

  assign awready = !aw_hold_reg && !bvalid;
  assign wready = !w_hold_reg && !bvalid;
  assign wr_en = aw_hold_reg && w_hold_reg && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // Capture address and data in either order
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else if (wr_en)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_reg <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_reg <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
    end
  end

  // Write response after both halves are in
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read data one cycle after the address is taken
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule : sac_axil_slave

// [design/sac_top.sv]
// Successive-approximation converter control: routing, clocking, sequencing,
// result registers and pin override, with registers over AXI4-Lite.
// Assumes the analog core steps on CONV_TICK and holds CORE_RESULT at the end.
// Function
// - Analog-selected pin loses its digital function and its pull-high.
// - Analog selection overrides the port direction control of that pin.
// - Source code 0000 converts the external pin chosen by channel select.
// - Any internal source disconnects the external channel regardless of channel.
// - Decode internal sources: supply, half, quarter, amplifier by 1/2/4, ground.
// - Codes 0000, 0100 and 11xx all pick the external channel.
// - Start bit written high then low starts a conversion.
// - Busy flag set at successful start, cleared at completion.
// - Completion sets request flag; interrupt raised when both enables high.
// - Conversion clock is system clock divided by 1 up to 128.
// - Converter powered only while the power enable bit is high.
// - Four sampling periods then twelve conversion periods, sixteen total.
// - After busy falls the result sits in the high and low registers.
// - Format 0 gives bits 11..4 high; format 1 gives bits 11..8 high.
// - Clearing power enable leaves both result registers unchanged.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sac_top #(
  parameter int NPINS = 16,
  parameter int DIV_W = 7
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [sac_pkg::AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [sac_pkg::AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NPINS-1:0] PIN_ANALOG_SEL,
  input wire logic [NPINS-1:0] PIN_PULLUP_SET,
  input wire logic [NPINS-1:0] PIN_OUT_SET,
  output logic [NPINS-1:0] PIN_PULLUP_EN,
  output logic [NPINS-1:0] PIN_OUT_EN,
  output logic [NPINS-1:0] PIN_DIGITAL_OFF,
  output sac_pkg::sac_route_t ANALOG_ROUTE,
  output logic [7:0] REF_CTRL,
  output logic CONV_POWER,
  output logic SAMPLE_EN,
  output logic CONVERT_EN,
  output logic CONV_TICK,
  input wire logic [11:0] CORE_RESULT,
  output logic CONV_IRQ
);
  import sac_pkg::*;

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ref_reg;
  logic [1:0] ien_reg;
  logic flag_reg;
  logic busy_reg;
  logic [7:0] res_hi_reg;
  logic [7:0] res_lo_reg;
  sac_state_t state_reg;
  logic [4:0] tick_cnt_reg;
  logic tick;
  logic wr_lane0;
  logic start_go;
  logic done;
  logic power;

  // Register bus front end
  sac_axil_slave u_bus (
    .clk(CLK_SYS),
    .nrst(NRST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Conversion clock enable
  sac_clk_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk(CLK_SYS),
    .nrst(NRST),
    .sync_clr(start_go),
    .sel(ctrl1_reg[C1_DIV +: 3]),
    .tick(tick)
  );

  // Lane-0 write strobe and the stored power bit
  assign wr_lane0 = wr_en && wr_strb[0];
  assign power = ctrl0_reg[C0_PWR];
  // Start on the falling write of a high start bit, only when powered
  assign start_go = wr_lane0 && (wr_addr == OFS_CTRL0) && ctrl0_reg[C0_START] &&
                    !wr_data[C0_START] && wr_data[C0_PWR];
  assign done = tick && (state_reg == ST_CONVERT) && (tick_cnt_reg == TOTAL_TICKS - 5'h01);

  // Control register writes
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
      ref_reg <= REF_RST;
      ien_reg <= INT_RST[1:0];
    end
    else if (wr_lane0)
    begin
      case (wr_addr)
        OFS_CTRL0: ctrl0_reg <= wr_data[7:0];
        OFS_CTRL1: ctrl1_reg <= {wr_data[7:4], 1'b0, wr_data[2:0]};
        OFS_REF: ref_reg <= {wr_data[7], 2'b00, wr_data[4:0]};
        OFS_INT: ien_reg <= {wr_data[INT_CIE], wr_data[INT_GIE]};
        default: ;
      endcase
    end
  end

  // Request flag: completion sets, write of zero clears, set wins
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      flag_reg <= 1'b0;
    else if (done)
      flag_reg <= 1'b1;
    else if (wr_lane0 && wr_addr == OFS_INT && !wr_data[INT_FLAG])
      flag_reg <= 1'b0;
  end

  // Sequencer: sample for four ticks, convert for twelve
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= ST_IDLE;
      tick_cnt_reg <= 5'h00;
    end
    else if (!power)
      state_reg <= ST_IDLE;
    else if (start_go)
    begin
      state_reg <= ST_SAMPLE;
      tick_cnt_reg <= 5'h00;
    end
    else if (tick)
    begin
      case (state_reg)
        ST_SAMPLE:
        begin
          tick_cnt_reg <= tick_cnt_reg + 5'h01;
          if (tick_cnt_reg == SAMPLE_TICKS - 5'h01)
            state_reg <= ST_CONVERT;
        end
        ST_CONVERT:
        begin
          tick_cnt_reg <= tick_cnt_reg + 5'h01;
          if (done)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Busy flag follows start and completion
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      busy_reg <= 1'b0;
    else if (!power)
      busy_reg <= 1'b0;
    else if (start_go)
      busy_reg <= 1'b1;
    else if (done)
      busy_reg <= 1'b0;
  end

  // Result capture on the completion edge, kept when powered down
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      res_hi_reg <= 8'h00;
      res_lo_reg <= 8'h00;
    end
    else if (done)
    begin
      if (ctrl0_reg[C0_FMT])
      begin
        res_hi_reg <= {4'h0, CORE_RESULT[11:8]};
        res_lo_reg <= CORE_RESULT[7:0];
      end
      else
      begin
        res_hi_reg <= CORE_RESULT[11:4];
        res_lo_reg <= {CORE_RESULT[3:0], 4'h0};
      end
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFS_CTRL0: rd_data[7:0] = {ctrl0_reg[7], busy_reg, ctrl0_reg[5:0]};
      OFS_CTRL1: rd_data[7:0] = ctrl1_reg;
      OFS_REF: rd_data[7:0] = ref_reg;
      OFS_RES_HI: rd_data[7:0] = res_hi_reg;
      OFS_RES_LO: rd_data[7:0] = res_lo_reg;
      OFS_INT: rd_data[7:0] = {5'h00, flag_reg, ien_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Analog routing and power
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ANALOG_ROUTE <= '0;
      REF_CTRL <= REF_RST;
      CONV_POWER <= 1'b0;
    end
    else
    begin
      ANALOG_ROUTE <= decode_route(ctrl1_reg[C1_SRC +: 4], ctrl0_reg[C0_CHAN +: 4]);
      REF_CTRL <= ref_reg;
      CONV_POWER <= power;
    end
  end

  // Pin override for analog-selected pins
  generate
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
      always_ff @(posedge CLK_SYS or negedge NRST)
      begin
        if (!NRST)
        begin
          PIN_PULLUP_EN[i] <= 1'b0;
          PIN_OUT_EN[i] <= 1'b0;
          PIN_DIGITAL_OFF[i] <= 1'b0;
        end
        else
        begin
          PIN_PULLUP_EN[i] <= PIN_PULLUP_SET[i] && !PIN_ANALOG_SEL[i];
          PIN_OUT_EN[i] <= PIN_OUT_SET[i] && !PIN_ANALOG_SEL[i];
          PIN_DIGITAL_OFF[i] <= PIN_ANALOG_SEL[i];
        end
      end
    end
  endgenerate

  // Phase levels, gated conversion tick and the masked interrupt line
  assign SAMPLE_EN = (state_reg == ST_SAMPLE);
  assign CONVERT_EN = (state_reg == ST_CONVERT);
  assign CONV_TICK = tick && (state_reg != ST_IDLE);
  assign CONV_IRQ = flag_reg && ien_reg[INT_GIE] && ien_reg[INT_CIE];
endmodule : sac_top

// [verification/sac_checker.sv]
// Port-level assertions for the converter control top module.
// Bound into every sac_top instance; sees only its ports.
`timescale 1ns/1ns
module sac_checker #(
  parameter int NPINS = 16
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [NPINS-1:0] PIN_ANALOG_SEL,
  input wire logic [NPINS-1:0] PIN_PULLUP_EN,
  input wire logic [NPINS-1:0] PIN_OUT_EN,
  input wire logic [NPINS-1:0] PIN_DIGITAL_OFF,
  input wire sac_pkg::sac_route_t ANALOG_ROUTE,
  input wire logic SAMPLE_EN,
  input wire logic CONVERT_EN,
  input wire logic CONV_TICK
);
  import sac_pkg::*;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  // Conversion phase only ever begins out of sampling
  sequence s_enter_conv;
    !CONVERT_EN ##1 CONVERT_EN;
  endsequence

  // Pin override, routing, phase and bus hold checks
  a_pullup_drop: assert property ($past(NRST) |-> !(PIN_PULLUP_EN & $past(PIN_ANALOG_SEL)))
    else $error("pull-high left on an analog pin");
  a_digital_off: assert property ($past(NRST) |-> PIN_DIGITAL_OFF == $past(PIN_ANALOG_SEL))
    else $error("digital function not removed");
  a_dir_override: assert property ($past(NRST) |-> !(PIN_OUT_EN & $past(PIN_ANALOG_SEL)))
    else $error("output driver left on an analog pin");
  a_internal_cut: assert property (ANALOG_ROUTE.src != SRC_EXT |-> !ANALOG_ROUTE.ext_en)
    else $error("external channel joined to internal source");
  a_ext_path: assert property ($past(NRST) && ANALOG_ROUTE.src == SRC_EXT |-> ANALOG_ROUTE.ext_en)
    else $error("external source without channel path");
  a_phase_excl: assert property (!(SAMPLE_EN && CONVERT_EN))
    else $error("sampling and converting together");
  a_sample_first: assert property (s_enter_conv |-> $past(SAMPLE_EN, 1))
    else $error("conversion entered without sampling");
  a_tick_active: assert property (CONV_TICK |-> SAMPLE_EN || CONVERT_EN)
    else $error("conversion tick while idle");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
endmodule : sac_checker

bind sac_top sac_checker #(.NPINS(NPINS)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .PIN_ANALOG_SEL(PIN_ANALOG_SEL), .PIN_PULLUP_EN(PIN_PULLUP_EN),
  .PIN_OUT_EN(PIN_OUT_EN), .PIN_DIGITAL_OFF(PIN_DIGITAL_OFF), .ANALOG_ROUTE(ANALOG_ROUTE),
  .SAMPLE_EN(SAMPLE_EN), .CONVERT_EN(CONVERT_EN), .CONV_TICK(CONV_TICK));

// [verification/tb_sac_top.sv]
// Self-checking bench for the converter control block.
// Drives the AXI4-Lite port and pins directly; analog core result is a bench value.
`timescale 1ns/1ns
module tb_sac_top;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_power, sample_en, convert_en, conv_irq;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] asel = 16'h0, pull_set = 16'h0, out_set = 16'h0, pull_en, out_en, dig_off;
  logic [11:0] core = 12'h0;
  logic [7:0] ref_ctrl;
  // Settling wait after power-up, in clocks; a plain bench figure
  localparam int SETTLE_CYCLES = 16;
  sac_route_t route;
  int failures = 0, samples_checked = 0, ns = 0, nc = 0;

  sac_top uut (.CLK_SYS(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_ANALOG_SEL(asel), .PIN_PULLUP_SET(pull_set), .PIN_OUT_SET(out_set),
    .PIN_PULLUP_EN(pull_en), .PIN_OUT_EN(out_en), .PIN_DIGITAL_OFF(dig_off),
    .ANALOG_ROUTE(route), .REF_CTRL(ref_ctrl), .CONV_POWER(conv_power), .SAMPLE_EN(sample_en),
    .CONVERT_EN(convert_en), .CONV_TICK(), .CORE_RESULT(core), .CONV_IRQ(conv_irq));

  initial forever #4 clk = ~clk;

  // Phase lengths counted away from the active edge
  always @(negedge clk)
  begin
    if (sample_en) ns++;
    if (convert_en) nc++;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while ((awvalid && !ta) || (wvalid && !tw));
    do @(negedge clk); while (!bvalid);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    while (!t);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rv = rdata;
    rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // Two writes: start high then low, power on, channel 0
  task automatic start(input logic fmt);
    wr(OFS_CTRL0, {3'b101, fmt, 4'h0});
    wr(OFS_CTRL0, {3'b001, fmt, 4'h0});
  endtask : start

  task automatic t_regs();
    rd(OFS_CTRL0);
    chk("ctrl0 reset", rv, 32'h0);
    rd(OFS_CTRL1);
    chk("ctrl1 reset", rv, 32'h0);
    rd(8'h18);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("unmapped data", rv, 32'h0);
    wr(8'h18, 8'h55);
    chk("unmapped write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_RES_HI, 8'hff);
    chk("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(OFS_RES_HI);
    chk("result read only", rv, 32'h0);
    wr(OFS_REF, 8'hff);
    rd(OFS_REF);
    chk("ref readback", rv, 32'h9f);
    chk("ref out", {24'h0, ref_ctrl}, 32'h9f);
  endtask : t_regs

  task automatic t_pins();
    @(posedge clk);
    asel <= 16'h0ff0;
    pull_set <= 16'hf0f0;
    out_set <= 16'h3c3c;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("pullup", {16'h0, pull_en}, 32'hf000);
    chk("digital off", {16'h0, dig_off}, 32'h0ff0);
    chk("direction", {16'h0, out_en}, 32'h300c);
  endtask : t_pins

  // Every source code with channel 9 held in the channel field
  task automatic t_route();
    sac_route_t er;
    logic [3:0] c;
    wr(OFS_CTRL0, 8'h09);
    for (int s = 0; s < 16; s++)
    begin
      c = s[3:0];
      wr(OFS_CTRL1, {c, 4'h0});
      @(negedge clk);
      er.ext_en = (c == 4'h0 || c == 4'h4 || c >= 4'hc);
      er.ext_sel = er.ext_en ? 4'h9 : 4'h0;
      er.src = er.ext_en ? SRC_EXT : (c[3] ? SRC_GND : (c[2] ? SRC_AMP : SRC_SUPPLY));
      er.div_shift = (er.ext_en || c[3]) ? 2'h0 : c[1:0] - 2'h1;
      chk("route", {23'h0, route}, {23'h0, er});
    end
  endtask : t_route

  task automatic t_conv(input logic [2:0] s, input logic fmt);
    logic [11:0] r;
    r = 12'h9c6 + 12'(s) * 12'h111;
    core <= r;
    wr(OFS_CTRL1, {5'h0, s});
    wr(OFS_CTRL0, {3'b001, fmt, 4'h0});
    repeat (SETTLE_CYCLES) @(posedge clk);
    ns = 0;
    nc = 0;
    start(fmt);
    chk("power", {31'h0, conv_power}, 32'h1);
    rd(OFS_CTRL0);
    chk("busy", {31'h0, rv[6]}, 32'h1);
    do rd(OFS_CTRL0); while (rv[6] === 1'b1);
    chk("sample cycles", ns, 32'h4 << s);
    chk("convert cycles", nc, 32'hc << s);
    rd(OFS_RES_HI);
    chk("result hi", rv, fmt ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
    rd(OFS_RES_LO);
    chk("result lo", rv, fmt ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
    rd(OFS_INT);
    chk("request flag", {31'h0, rv[2]}, 32'h1);
    chk("irq", {31'h0, conv_irq}, 32'h1);
    wr(OFS_INT, 8'h03);
    chk("irq cleared", {31'h0, conv_irq}, 32'h0);
  endtask : t_conv

  // Second start lands in the conversion phase of the first
  task automatic t_restart();
    core <= 12'h3e1;
    wr(OFS_CTRL1, 8'h01);
    ns = 0;
    start(1'b0);
    repeat (10) @(posedge clk);
    start(1'b0);
    rd(OFS_CTRL0);
    chk("busy held", {31'h0, rv[6]}, 32'h1);
    do rd(OFS_CTRL0); while (rv[6] === 1'b1);
    chk("resampled", ns, 32'h10);
    wr(OFS_INT, 8'h05);
    chk("irq masked", {31'h0, conv_irq}, 32'h0);
    wr(OFS_INT, 8'h03);
  endtask : t_restart

  // Power dropped mid-run: no result update, no flag
  task automatic t_abort();
    core <= 12'h777;
    start(1'b0);
    repeat (3) @(posedge clk);
    wr(OFS_CTRL0, 8'h00);
    repeat (40) @(posedge clk);
    chk("power off", {31'h0, conv_power}, 32'h0);
    rd(OFS_CTRL0);
    chk("busy off", {31'h0, rv[6]}, 32'h0);
    rd(OFS_RES_HI);
    chk("result kept", rv, 32'h3e);
    rd(OFS_INT);
    chk("no flag", {31'h0, rv[2]}, 32'h0);
  endtask : t_abort

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the longest divider run
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_pins();
    t_route();
    wr(OFS_INT, 8'h03);
    // Only divider code 7 gives a legal period at this clock; faster codes check counting
    for (int s = 0; s < 8; s++)
      t_conv(3'(s), s[0]);
    t_restart();
    t_abort();
    end_of_test();
  end
endmodule : tb_sac_top
